/* File: fsi_consts.svh */
// Constants for the fault status indicator
`ifndef FSI_CONSTS_SVH
`define FSI_CONSTS_SVH
`define FSI_CLK_HZ 50000000
`define FSI_RECOVERY_MIN 5
`define FSI_RECOVERY_CYC (64'h1 * `FSI_RECOVERY_MIN * 60 * `FSI_CLK_HZ)
`define FSI_FLASH_MS 250
`define FSI_FLASH_CYC (`FSI_FLASH_MS * (`FSI_CLK_HZ / 1000))
`define FSI_PAUSE_SLOTS 6
`define FSI_CNT_PHASE 4'h2
`define FSI_CNT_VOLT 4'h3
`define FSI_CNT_FREQ 4'h4
`define FSI_CNT_OC_RAMP 4'h5
`define FSI_CNT_RAMP_TO 4'h6
`define FSI_CNT_TEMP 4'h7
`define FSI_CNT_OC_BYP 4'h8
`define FSI_CNT_UNBAL 4'h9
`endif

/* File: fsi_pkg.sv */
// Types for the fault status indicator
`default_nettype none
package fsi_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_RAMPING, ST_BYPASS, ST_RECOVERY, ST_ALARM} fsi_op_type;
	typedef enum logic [3:0] {
		FLT_NONE, FLT_PHASE, FLT_VOLT, FLT_FREQ, FLT_OC_RAMP, FLT_RAMP_TO,
		FLT_TEMP, FLT_OC_BYP, FLT_UNBAL, FLT_INTERNAL
	} fsi_fault_type;
	typedef enum logic [1:0] {VAR_SMALL_STD, VAR_SMALL_HP, VAR_LARGE} fsi_variant_type;
endpackage
`default_nettype wire

/* File: fsi_flasher.sv */
// Flash-count sequencer for one LED
`default_nettype none
`include "fsi_consts.svh"
module fsi_flasher #(
	parameter int unsigned SLOT_CYC = `FSI_FLASH_CYC,
	parameter int unsigned PAUSE_SLOTS = `FSI_PAUSE_SLOTS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [3:0] count,
	output logic led
);
	localparam int unsigned SW = $clog2(SLOT_CYC + 1);
	logic [SW-1:0] tick_q, tick_d;
	logic [4:0] slot_q, slot_d;
	logic [4:0] total;
	logic slot_end;
	always_comb begin
		total = 5'({count, 1'b0}) + 5'(PAUSE_SLOTS);
		slot_end = (tick_q == SW'(SLOT_CYC - 1));
		tick_d = slot_end ? '0 : tick_q + SW'(1);
		slot_d = slot_q;
		if (slot_end) begin
			slot_d = (slot_q >= total - 5'h01) ? 5'h00 : slot_q + 5'h01;
		end
		if (!run) begin
			tick_d = '0;
			slot_d = 5'h00;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q <= '0;
			slot_q <= 5'h00;
		end else begin
			tick_q <= tick_d;
			slot_q <= slot_d;
		end
	end
	// On in even slots of the group, then a dark pause
	assign led = run && !slot_q[0] && (slot_q < 5'({count, 1'b0}));
endmodule // fsi_flasher
`default_nettype wire

/* File: fsi_indicator.sv */
// Fault status indicator top: LEDs, relays and auto-reset recovery
`default_nettype none
`include "fsi_consts.svh"
module fsi_indicator
	import fsi_pkg::*;
#(
	parameter longint unsigned RECOVERY_CYC = `FSI_RECOVERY_CYC,
	parameter int unsigned SLOT_CYC = `FSI_FLASH_CYC,
	parameter fsi_pkg::fsi_variant_type VARIANT = fsi_pkg::VAR_SMALL_STD
) (
	input wire logic CLK,
	input wire logic RST,
	input wire fsi_pkg::fsi_op_type OP_STATE,
	input wire fsi_pkg::fsi_fault_type FAULT,
	input wire logic FAULT_VALID,
	input wire logic PHASE_ONE_OK,
	input wire logic PHASE_TWO_OK,
	input wire logic PHASE_THREE_OK,
	output logic GREEN_LED,
	output logic RED_LED,
	output logic ALARM_RELAY_NO,
	output logic BYPASS_RELAY_NO,
	output logic ALARM_ACTIVE,
	output logic RECOVERING
);
	import fsi_pkg::*;
	localparam int unsigned RW = $clog2(RECOVERY_CYC + 1);

	function automatic logic [3:0] flash_count(input fsi_fault_type f);
		unique case (f)
			FLT_PHASE: flash_count = `FSI_CNT_PHASE;
			FLT_VOLT: flash_count = `FSI_CNT_VOLT;
			FLT_FREQ: flash_count = `FSI_CNT_FREQ;
			FLT_OC_RAMP: flash_count = `FSI_CNT_OC_RAMP;
			FLT_RAMP_TO: flash_count = `FSI_CNT_RAMP_TO;
			FLT_TEMP: flash_count = `FSI_CNT_TEMP;
			FLT_OC_BYP: flash_count = `FSI_CNT_OC_BYP;
			FLT_UNBAL: flash_count = `FSI_CNT_UNBAL;
			default: flash_count = 4'h0;
		endcase
	endfunction

	typedef enum logic [1:0] {AL_CLEAR, AL_FLASH, AL_RECOVER, AL_STEADY} fsi_alarm_type;
	fsi_alarm_type al_q, al_d;
	fsi_fault_type flt_q, flt_d;
	logic [RW-1:0] rec_q, rec_d;
	logic all_phases;
	logic green_d, red_d, arel_d, brel_d;
	logic green_q, red_q, arel_q, brel_q;
	logic red_flash, green_flash;
	logic alarm_view, recov_view, bypass_view, ramp_view;

	always_comb begin
		al_d = al_q;
		flt_d = flt_q;
		rec_d = rec_q;
		all_phases = PHASE_ONE_OK && PHASE_TWO_OK && PHASE_THREE_OK;
		unique case (al_q)
			AL_CLEAR: begin
				if (FAULT_VALID && FAULT != FLT_NONE) begin
					if (FAULT == FLT_INTERNAL) begin
						if (VARIANT == VAR_SMALL_HP) begin
							al_d = AL_STEADY;
						end
					end else begin
						al_d = AL_FLASH;
						flt_d = FAULT;
					end
				end
			end
			AL_FLASH: begin
				// Wrong phase order stays until reset; unbalance waits for all phases
				if (flt_q != FLT_PHASE && (flt_q != FLT_UNBAL || all_phases)) begin
					al_d = AL_RECOVER;
					rec_d = '0;
				end
			end
			AL_RECOVER: begin
				if (rec_q == RW'(RECOVERY_CYC - 1)) begin
					al_d = AL_CLEAR;
					flt_d = FLT_NONE;
				end else begin
					rec_d = rec_q + RW'(1);
				end
			end
			AL_STEADY: begin
				al_d = AL_STEADY;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			al_q <= AL_CLEAR;
			flt_q <= FLT_NONE;
			rec_q <= '0;
		end else begin
			al_q <= al_d;
			flt_q <= flt_d;
			rec_q <= rec_d;
		end
	end

	fsi_flasher #(.SLOT_CYC(SLOT_CYC)) u_red (
		.clk(CLK),
		.rst(RST),
		.run(al_q == AL_FLASH),
		.count(flash_count(flt_q)),
		.led(red_flash)
	);

	fsi_flasher #(.SLOT_CYC(SLOT_CYC), .PAUSE_SLOTS(0)) u_green (
		.clk(CLK),
		.rst(RST),
		.run(recov_view),
		.count(4'h1),
		.led(green_flash)
	);

	always_comb begin
		alarm_view = (al_q == AL_FLASH) || (al_q == AL_STEADY) || (OP_STATE == ST_ALARM);
		recov_view = !alarm_view && ((al_q == AL_RECOVER) || (OP_STATE == ST_RECOVERY));
		bypass_view = !alarm_view && !recov_view && (OP_STATE == ST_BYPASS);
		ramp_view = !alarm_view && !recov_view && (OP_STATE == ST_RAMPING);
		green_d = recov_view ? green_flash : 1'b1;
		red_d = 1'b0;
		if (al_q == AL_STEADY) begin
			red_d = 1'b1;
		end else if (alarm_view) begin
			red_d = red_flash;
		end
		// Relay output high means the 11/12 (alarm) or 21/24 (bypass) position
		unique case (VARIANT)
			VAR_SMALL_STD: arel_d = alarm_view || ramp_view;
			VAR_SMALL_HP: arel_d = alarm_view;
			default: arel_d = !alarm_view;
		endcase
		brel_d = (VARIANT == VAR_LARGE) && bypass_view;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			green_q <= 1'b0;
			red_q <= 1'b0;
			arel_q <= 1'b0;
			brel_q <= 1'b0;
			ALARM_ACTIVE <= 1'b0;
			RECOVERING <= 1'b0;
		end else begin
			green_q <= green_d;
			red_q <= red_d;
			arel_q <= arel_d;
			brel_q <= brel_d;
			ALARM_ACTIVE <= alarm_view;
			RECOVERING <= recov_view;
		end
	end

	assign GREEN_LED = green_q;
	assign RED_LED = red_q;
	assign ALARM_RELAY_NO = arel_q;
	assign BYPASS_RELAY_NO = brel_q;
endmodule // fsi_indicator
`default_nettype wire

/* File: fsi_props.sv */
// Checker for the fault status indicator
`default_nettype none
module fsi_props
	import fsi_pkg::*;
#(parameter longint unsigned RECOVERY_CYC = 50, parameter int unsigned SLOT_CYC = 4) (
	input wire logic CLK,
	input wire logic RST,
	input wire fsi_pkg::fsi_op_type OP_STATE,
	input wire fsi_pkg::fsi_fault_type FAULT,
	input wire logic FAULT_VALID,
	input wire logic GREEN_LED,
	input wire logic RED_LED,
	input wire logic ALARM_RELAY_NO,
	input wire logic BYPASS_RELAY_NO,
	input wire logic ALARM_ACTIVE,
	input wire logic RECOVERING
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [31:0] rec_q, red_q;
	wire quiet = !ALARM_ACTIVE && !RECOVERING;
	always_ff @(posedge CLK) begin
		rec_q <= RECOVERING ? rec_q + 32'h1 : 32'h0;
		red_q <= RED_LED ? red_q + 32'h1 : 32'h0;
	end
	property p_idle; (OP_STATE == ST_IDLE && quiet)[*3] |-> GREEN_LED && !RED_LED; endproperty
	a_idle: assert property (p_idle) else $error("idle view");
	property p_byp; (OP_STATE == ST_BYPASS && quiet)[*3] |-> !ALARM_RELAY_NO && !BYPASS_RELAY_NO; endproperty
	a_byp: assert property (p_byp) else $error("bypass relays");
	property p_alarm; ALARM_ACTIVE[*3] |-> ALARM_RELAY_NO; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm relay");
	property p_phase; FAULT_VALID && FAULT == FLT_PHASE && quiet |-> ##[1:3] ALARM_ACTIVE[*8]; endproperty
	a_phase: assert property (p_phase) else $error("phase alarm");
	property p_int; FAULT_VALID && !$past(FAULT_VALID) && FAULT == FLT_INTERNAL && quiet |=> !ALARM_ACTIVE[*4]; endproperty
	a_int: assert property (p_int) else $error("internal taken");
	property p_rec; rec_q <= RECOVERY_CYC + 2; endproperty
	a_rec: assert property (p_rec) else $error("recovery long");
	property p_flash; $rose(RECOVERING) |-> ##[1:6] !$stable(GREEN_LED); endproperty
	a_flash: assert property (p_flash) else $error("green steady");
	property p_slot; red_q <= SLOT_CYC; endproperty
	a_slot: assert property (p_slot) else $error("red steady");
	cover property ($rose(RECOVERING));
	cover property (ALARM_ACTIVE && RED_LED);
	cover property (OP_STATE == ST_BYPASS && quiet);
endmodule // fsi_props
bind fsi_indicator fsi_props #(.RECOVERY_CYC(RECOVERY_CYC), .SLOT_CYC(SLOT_CYC)) i_props (
	.CLK, .RST, .OP_STATE, .FAULT, .FAULT_VALID, .GREEN_LED, .RED_LED, .ALARM_RELAY_NO,
	.BYPASS_RELAY_NO, .ALARM_ACTIVE, .RECOVERING);
`default_nettype wire

/* File: fsi_operator.sv */
// Operator model counting the red flashes in each group
`default_nettype none
module fsi_operator (
	input wire logic clk,
	input wire logic red,
	output var int cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	int k = 0;
	int dark = 0;
	always @(posedge clk) begin
		dark <= (red === 1'b1) ? 0 : dark + 1;
		if (red === 1'b1 && dark > 0) k <= k + 1;
		if (dark == 12 && k > 0) begin
			cnt <= k;
			k <= 0;
		end
	end
endmodule // fsi_operator
`default_nettype wire

/* File: testbench.sv */
// Bench for the fault status indicator
`default_nettype none
module testbench;
	import fsi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RST = 1, fv = 0, p2 = 1;
	fsi_op_type op = ST_IDLE;
	fsi_fault_type flt = FLT_NONE;
	fsi_fault_type au[$] = '{FLT_VOLT, FLT_FREQ, FLT_OC_RAMP, FLT_RAMP_TO, FLT_TEMP, FLT_OC_BYP};
	fsi_op_type ops[3] = '{ST_IDLE, ST_RAMPING, ST_BYPASS};
	logic g, r, ar, br, aa, rc;
	int num_errors = 0, n_tests = 0, seed = 12399, n, cnt;
	always #10 CLK = ~CLK;
	fsi_indicator #(.RECOVERY_CYC(50), .SLOT_CYC(4)) i_dut (.CLK(CLK), .RST(RST),
		.OP_STATE(op), .FAULT(flt), .FAULT_VALID(fv), .PHASE_ONE_OK(1'b1),
		.PHASE_TWO_OK(p2), .PHASE_THREE_OK(1'b1), .GREEN_LED(g), .RED_LED(r),
		.ALARM_RELAY_NO(ar), .BYPASS_RELAY_NO(br), .ALARM_ACTIVE(aa), .RECOVERING(rc));
	fsi_operator i_op (.clk(CLK), .red(r), .cnt(cnt));
	task step(int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task chk(logic ok, string m);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task fire(fsi_fault_type f);
		flt = f;
		fv = 1;
		step(1);
		fv = 0;
	endtask
	task recover;
		n = 0;
		step(4);
		while (rc === 1'b1 && n < 99) begin
			step(1);
			n++;
		end
		chk(n > 43 && n < 53, "recovery");
	endtask
	task test_done;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		step(10);
		RST = 0;
		foreach (ops[k]) begin
			op = ops[k];
			step(4);
			chk(g === 1'b1 && r === 1'b0 && ar === (k == 1) && br === 1'b0, "view");
		end
		op = ST_IDLE;
		fire(FLT_PHASE);
		fv = 1;
		repeat (150) begin
			flt = fsi_fault_type'($unsigned($random(seed)) % 10);
			step(1);
		end
		fv = 0;
		step(50);
		chk(cnt == 2 && aa === 1'b1 && ar === 1'b1, "phase");
		RST = 1;
		step(10);
		RST = 0;
		step(1);
		fire(FLT_INTERNAL);
		step(4);
		chk(aa === 1'b0, "internal");
		p2 = 0;
		fire(FLT_UNBAL);
		step(300);
		chk(cnt == 9 && aa === 1'b1, "unbalance");
		p2 = 1;
		recover();
		foreach (au[k]) begin
			fire(au[k]);
			recover();
		end
		test_done();
	end
	initial begin
		#100us;
		num_errors++;
		test_done();
	end
endmodule // testbench
`default_nettype wire
